// file: logic/rtctc_bcd_counter.sv
/*
  Two-digit BCD counter stage with load, wrap at a top value and carry.
  Assumes inc and load come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rtctc_bcd_counter
  import rtctc_pkg::*;
#(
  parameter int TENS_W = 3,
  parameter logic [3:0] TOP_TENS = 4'h5,
  parameter logic [3:0] TOP_UNITS = 4'h9
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inc,
  input wire logic load,
  input wire logic [7:0] load_data,
  output logic [7:0] value,
  output logic carry
);

  logic [TENS_W-1:0] tens_r;
  logic [TENS_W-1:0] tens_nxt;
  logic [3:0] units_r;
  logic [3:0] units_nxt;
  logic at_top;

  assign at_top = (4'(tens_r) == TOP_TENS) && (units_r == TOP_UNITS);
  assign carry = inc && at_top;
  assign value = 8'({tens_r, units_r});

  always_comb begin
    tens_nxt = tens_r;
    units_nxt = units_r;
    if (load) begin
      tens_nxt = load_data[TENS_LSB +: TENS_W];
      units_nxt = load_data[UNITS_LSB +: UNITS_W];
    end else if (inc) begin
      if (at_top) begin
        tens_nxt = '0;
        units_nxt = '0;
      end else if (units_r == DIGIT_TOP) begin
        units_nxt = '0;
        tens_nxt = tens_r + TENS_W'(1);
      end else begin
        units_nxt = units_r + 4'h1;
      end
    end
  end

  // no reset: contents survive every reset
  always_ff @(posedge clk) begin
    tens_r <= tens_nxt;
    units_r <= units_nxt;
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_CNT_WRAP: assert property (inc && !load && at_top |=> value == 8'h00)
    else $error("counter did not wrap to zero at top");
  AST_CNT_HOLD: assert property (!inc && !load |=> $stable(value))
    else $error("counter moved without increment or load");

endmodule
`default_nettype wire

// file: logic/rtctc_pkg.sv
/*
  Shared constants of the timekeeping counter chain: register map,
  field layout, divider figures and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`default_nettype none
package rtctc_pkg;

  // ********************************************************
  // register map (byte offsets, one aligned word each)
  // ********************************************************
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] OFF_DIV = 8'h00;
  localparam logic [7:0] OFF_SEC = 8'h04;
  localparam logic [7:0] OFF_MIN = 8'h08;
  localparam logic [7:0] OFF_HR = 8'h0C;
  localparam logic [7:0] OFF_WK = 8'h10;
  localparam logic [7:0] OFF_CTRL2 = 8'h14;

  // ********************************************************
  // field layout
  // ********************************************************
  localparam int UNITS_LSB = 0;
  localparam int UNITS_W = 4;
  localparam int TENS_LSB = 4;
  localparam int SEC_TENS_W = 3;
  localparam int HR_TENS_W = 2;
  localparam int WK_W = 3;
  localparam int DIV_W = 7;
  localparam logic [3:0] DIGIT_TOP = 4'h9;
  localparam logic [3:0] SEC_TOP_TENS = 4'h5;
  localparam logic [3:0] HR_TOP_TENS = 4'h2;
  localparam logic [3:0] HR_TOP_UNITS = 4'h3;
  localparam logic [2:0] WK_TOP = 3'h6;
  localparam logic [2:0] WK_ZERO = 3'h0;
  localparam logic [2:0] WK_ONE = 3'h1;

  // control register two bits
  localparam int START_BIT = 0;
  localparam int DIVRST_BIT = 1;
  localparam int ADJ_BIT = 2;

  // ********************************************************
  // divider figures
  // ********************************************************
  localparam int OSC_HZ = 32768;
  localparam int DIV_IN_HZ = 128;
  localparam int PRE_COUNT = OSC_HZ / DIV_IN_HZ;
  localparam logic [7:0] PRE_TOP = 8'(PRE_COUNT - 1);
  localparam logic [7:0] PRE_ONE = 8'h01;
  localparam logic [6:0] DIV_TOP = 7'h7F;
  localparam logic [6:0] DIV_ONE = 7'h01;

  // ********************************************************
  // bus responses
  // ********************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// file: logic/rtctc_top.sv
/*
  Timekeeping counter chain: oscillator prescaler, seven-stage
  sub-second divider, BCD seconds, minutes, hours and a weekday counter,
  with an AXI4-Lite register slave.
  Assumes OSC_32K is the free-running 32.768 kHz oscillator, asynchronous
  to REF_CLK, and that software stops counting before loading counters.

  // Function
  // - divider view read-only, bit 7 zero
  // - view bits 6..0 are 1Hz..64Hz stages
  // - divider reset or adjust bit clears divider
  // - divider untouched by any reset
  // - seconds advance on once-per-second carry
  // - seconds BCD tens 6..4, units 3..0
  // - time counters untouched by any reset
  // - minutes advance on seconds carry
  // - minutes BCD layout, legal 00 to 59
  // - hours advance on minutes carry
  // - hours BCD tens 5..4, legal 00 to 23
  // - weekday advances on daily carry
  // - weekday code bits 2..0, 0 to 6
*/
`timescale 1ns/1ps
`default_nettype none
module rtctc_top
  import rtctc_pkg::*;
#(
  parameter int ADDR_W = REG_ADDR_W
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic OSC_32K,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFF_DIV) || hit(a, OFF_SEC) || hit(a, OFF_MIN) ||
             hit(a, OFF_HR) || hit(a, OFF_WK) || hit(a, OFF_CTRL2);
  endfunction

  // ********************************************************
  // oscillator sync and divider chain
  // ********************************************************
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  logic [7:0] pre_r;
  logic [7:0] pre_nxt;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic osc_rise, pre_wrap, div_carry, div_clr;

  assign osc_rise = osc_s2_r && !osc_s3_r;
  assign pre_wrap = osc_rise && (pre_r == PRE_TOP);
  assign div_carry = pre_wrap && (div_r == DIV_TOP);

  always_comb begin
    pre_nxt = pre_r;
    div_nxt = div_r;
    if (div_clr) begin
      pre_nxt = '0;
      div_nxt = '0;
    end else if (osc_rise) begin
      pre_nxt = pre_wrap ? 8'h00 : pre_r + PRE_ONE;
      if (pre_wrap) begin
        div_nxt = div_r + DIV_ONE;
      end
    end
  end

  // no reset on the chain: it keeps running through resets
  always_ff @(posedge REF_CLK) begin
    osc_s1_r <= OSC_32K;
    osc_s2_r <= osc_s1_r;
    osc_s3_r <= osc_s2_r;
    pre_r <= pre_nxt;
    div_r <= div_nxt;
  end

  // ********************************************************
  // bus slave state
  // ********************************************************
  logic [ADDR_W-1:0] awaddr_r;
  logic [ADDR_W-1:0] awaddr_nxt;
  logic aw_held_r;
  logic aw_held_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic wstrb0_r;
  logic wstrb0_nxt;
  logic w_held_r;
  logic w_held_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic start_r, start_nxt;
  logic [WK_W-1:0] wk_r;
  logic [WK_W-1:0] wk_nxt;
  logic do_write, wr_en;
  logic ld_sec, ld_min, ld_hr, ld_wk;
  logic sec_inc, min_inc, hr_inc, wk_inc;
  logic sec_carry, min_carry, hr_carry;
  logic [7:0] sec_val, min_val, hr_val;

  assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY = !w_held_r && !bvalid_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  assign do_write = aw_held_r && w_held_r;
  assign wr_en = do_write && wstrb0_r;
  assign ld_sec = wr_en && hit(awaddr_r, OFF_SEC);
  assign ld_min = wr_en && hit(awaddr_r, OFF_MIN);
  assign ld_hr = wr_en && hit(awaddr_r, OFF_HR);
  assign ld_wk = wr_en && hit(awaddr_r, OFF_WK);
  assign div_clr = wr_en && hit(awaddr_r, OFF_CTRL2) &&
                   (wdata_r[DIVRST_BIT] || wdata_r[ADJ_BIT]);

  // carries gated by the start bit
  assign sec_inc = start_r && div_carry;
  assign min_inc = start_r && sec_carry;
  assign hr_inc = start_r && min_carry;
  assign wk_inc = start_r && hr_carry;

  always_comb begin
    awaddr_nxt = awaddr_r;
    aw_held_nxt = aw_held_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    w_held_nxt = w_held_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    start_nxt = start_r;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      awaddr_nxt = S_AXI_AWADDR;
      aw_held_nxt = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      wdata_nxt = S_AXI_WDATA[7:0];
      wstrb0_nxt = S_AXI_WSTRB[0];
      w_held_nxt = 1'b1;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      if (wr_en && hit(awaddr_r, OFF_CTRL2)) begin
        start_nxt = wdata_r[START_BIT];
      end
    end else if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt = 32'h0000_0000;
      // upper bits of every view read as zero
      if (hit(S_AXI_ARADDR, OFF_DIV)) begin
        rdata_nxt = 32'(div_r);
      end else if (hit(S_AXI_ARADDR, OFF_SEC)) begin
        rdata_nxt = 32'(sec_val);
      end else if (hit(S_AXI_ARADDR, OFF_MIN)) begin
        rdata_nxt = 32'(min_val);
      end else if (hit(S_AXI_ARADDR, OFF_HR)) begin
        rdata_nxt = 32'(hr_val);
      end else if (hit(S_AXI_ARADDR, OFF_WK)) begin
        rdata_nxt = 32'(wk_r);
      end else if (hit(S_AXI_ARADDR, OFF_CTRL2)) begin
        rdata_nxt = 32'(start_r);
      end
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      awaddr_r <= '0;
      aw_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      start_r <= 1'b0;
    end else begin
      awaddr_r <= awaddr_nxt;
      aw_held_r <= aw_held_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      w_held_r <= w_held_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      start_r <= start_nxt;
    end
  end

  // ********************************************************
  // time counters
  // ********************************************************
  rtctc_bcd_counter #(
    .TENS_W(SEC_TENS_W),
    .TOP_TENS(SEC_TOP_TENS),
    .TOP_UNITS(DIGIT_TOP)
  ) u_sec (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .inc(sec_inc),
    .load(ld_sec),
    .load_data(wdata_r),
    .value(sec_val),
    .carry(sec_carry)
  );

  rtctc_bcd_counter #(
    .TENS_W(SEC_TENS_W),
    .TOP_TENS(SEC_TOP_TENS),
    .TOP_UNITS(DIGIT_TOP)
  ) u_min (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .inc(min_inc),
    .load(ld_min),
    .load_data(wdata_r),
    .value(min_val),
    .carry(min_carry)
  );

  rtctc_bcd_counter #(
    .TENS_W(HR_TENS_W),
    .TOP_TENS(HR_TOP_TENS),
    .TOP_UNITS(HR_TOP_UNITS)
  ) u_hr (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .inc(hr_inc),
    .load(ld_hr),
    .load_data(wdata_r),
    .value(hr_val),
    .carry(hr_carry)
  );

  always_comb begin
    wk_nxt = wk_r;
    if (ld_wk) begin
      wk_nxt = wdata_r[WK_W-1:0];
    end else if (wk_inc) begin
      wk_nxt = (wk_r == WK_TOP) ? WK_ZERO : wk_r + WK_ONE;
    end
  end

  // no reset: weekday survives every reset
  always_ff @(posedge REF_CLK) begin
    wk_r <= wk_nxt;
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_div_read;
    S_AXI_ARVALID && S_AXI_ARREADY && hit(S_AXI_ARADDR, OFF_DIV);
  endsequence

  AST_DIV_CLEAR: assert property (div_clr |=> div_r == '0)
    else $error("divider not cleared by control write");
  AST_DIV_STEP: assert property (pre_wrap && !div_clr |=>
    div_r == $past(div_r) + DIV_ONE)
    else $error("divider did not step on prescaler wrap");
  AST_DIV_READ: assert property (s_div_read |=> S_AXI_RVALID &&
    S_AXI_RDATA == 32'($past(div_r)))
    else $error("divider view read returned wrong data");
  AST_SEC_INC: assert property (start_r && div_carry && !ld_sec |=>
    sec_val != $past(sec_val))
    else $error("seconds missed the divider carry");
  AST_MIN_INC: assert property (start_r && sec_carry && !ld_min |=>
    min_val != $past(min_val))
    else $error("minutes missed the seconds carry");
  AST_WK_WRAP: assert property (wk_inc && !ld_wk && wk_r == WK_TOP |=>
    wk_r == WK_ZERO)
    else $error("weekday did not wrap after code six");
  AST_STOP_HOLD: assert property (!start_r && !wr_en |=>
    $stable(sec_val) && $stable(hr_val) && $stable(wk_r))
    else $error("counters moved while stopped");
  AST_WR_RESP: assert property (do_write |=> S_AXI_BVALID [*1] ##0
    (S_AXI_BRESP == ($past(mapped(awaddr_r)) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write response missing or wrong");

endmodule
`default_nettype wire

// file: tb/tb_rtc_time_counters.sv
/*
  Self-checking bench of the timekeeping counter chain over AXI4-Lite.
  Assumes the design package is compiled first; the bench drives the
  oscillator input itself, one rising edge every two REF_CLK cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_rtc_time_counters
  import rtctc_pkg::*;
;
  logic ref_clk, rst_b, osc;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int check_count = 0;

  rtctc_top u_rtctc_top (
    .REF_CLK(ref_clk), .RST_B(rst_b), .OSC_32K(osc),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready)
  );

  // ********************************************************
  // clock, verdict and watchdog
  // ********************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end

  // ********************************************************
  // bus and oscillator tasks
  // ********************************************************
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [1:0] er = RESP_OKAY);
    logic done;
    done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        `CHK(bresp, er)
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [7:0] e,
                        input logic [1:0] er = RESP_OKAY);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        `CHK(rdata, {24'h000000, e})
        `CHK(rresp, er)
      end
    end
  endtask

  // n rising oscillator edges, then time for the synchroniser
  task automatic osc_pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      osc <= 1'b1;
      @(posedge ref_clk);
      osc <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic rst_pulse();
    rst_b <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
  endtask

  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    rst_b = 1'b0;
    osc = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h00000000;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    // divider clear and stage counting
    axi_wr(OFF_CTRL2, 8'h02);
    axi_rd(OFF_DIV, 8'h00);
    osc_pulses(256 * 5);
    axi_rd(OFF_DIV, 8'h05);
    axi_wr(OFF_DIV, 8'hFF);
    axi_rd(OFF_DIV, 8'h05);
    rst_pulse();
    axi_rd(OFF_DIV, 8'h05);
    // loads with stray upper bits, counting stopped
    axi_wr(OFF_SEC, 8'hD9);
    axi_wr(OFF_MIN, 8'hD9);
    axi_wr(OFF_HR, 8'hE3);
    axi_wr(OFF_WK, 8'hFE);
    axi_rd(OFF_SEC, 8'h59);
    axi_rd(OFF_MIN, 8'h59);
    axi_rd(OFF_HR, 8'h23);
    axi_rd(OFF_WK, 8'h06);
    rst_pulse();
    axi_rd(OFF_SEC, 8'h59);
    axi_rd(OFF_MIN, 8'h59);
    axi_rd(OFF_HR, 8'h23);
    axi_rd(OFF_WK, 8'h06);
    axi_rd(OFF_CTRL2, 8'h00);
    // unmapped place
    axi_wr(8'h18, 8'h55, RESP_SLVERR);
    axi_rd(8'h1C, 8'h00, RESP_SLVERR);
    // start with adjust, run one whole second
    axi_wr(OFF_CTRL2, 8'h05);
    axi_rd(OFF_CTRL2, 8'h01);
    axi_rd(OFF_DIV, 8'h00);
    osc_pulses(256 * 127);
    axi_rd(OFF_DIV, 8'h7F);
    axi_rd(OFF_SEC, 8'h59);
    osc_pulses(256);
    axi_rd(OFF_DIV, 8'h00);
    axi_rd(OFF_SEC, 8'h00);
    axi_rd(OFF_MIN, 8'h00);
    axi_rd(OFF_HR, 8'h00);
    axi_rd(OFF_WK, 8'h00);
    // stop first, then load: counters hold, divider runs on
    axi_wr(OFF_CTRL2, 8'h00);
    axi_wr(OFF_SEC, 8'h30);
    osc_pulses(256 * 3);
    axi_rd(OFF_DIV, 8'h03);
    axi_rd(OFF_SEC, 8'h30);
    axi_rd(OFF_MIN, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
